//--- common/nvmac_defs.svh
// Offsets, bit positions, reset values and timing counts of the nonvolatile access control block
`ifndef NVMAC_DEFS_SVH
`define NVMAC_DEFS_SVH

`define NVMAC_ADDR_W            32
`define NVMAC_DATA_W            32
`define NVMAC_CTRL_OFFSET       32'h0000_0000
`define NVMAC_IRQ_STATUS_OFFSET 32'h0000_0004
`define NVMAC_IRQ_MASK_OFFSET   32'h0000_0008

`define NVMAC_BIT_READ_LAUNCH   0
`define NVMAC_BIT_WRITE_LAUNCH  1
`define NVMAC_BIT_PROGRAM_ALLOW 2
`define NVMAC_BIT_ABORT_FLAG    3
`define NVMAC_BIT_ROW_ERASE     4
`define NVMAC_BIT_UNUSED        5
`define NVMAC_BIT_CONFIG_SPACE  6
`define NVMAC_BIT_MEMORY_SPACE  7

`define NVMAC_IRQ_W             3
`define NVMAC_IRQ_WRITE_DONE    0
`define NVMAC_IRQ_READ_DONE     1
`define NVMAC_IRQ_ABORT         2

`define NVMAC_CTRL_RESET        8'h00
`define NVMAC_IRQ_STATUS_RESET  3'h0
`define NVMAC_IRQ_MASK_RESET    3'h0

`define NVMAC_RESP_OKAY         2'h0
`define NVMAC_RESP_SLVERR       2'h2

`define NVMAC_READ_CYCLES       1
`define NVMAC_SYNC_STAGES       3

`endif

//--- common/nvmac_pkg.sv
// Types shared by the nonvolatile access control block
`include "nvmac_defs.svh"

package nvmac_pkg;

    // Control and status register, bit 7 down to bit 0
    typedef struct packed {
        logic memory_space_select;
        logic config_space_select;
        logic unused;
        logic row_erase;
        logic cycle_abort_flag;
        logic program_allow;
        logic write_launch;
        logic read_launch;
    } nvmac_ctrl_t;

    typedef enum logic [1:0] {
        NVMAC_IDLE    = 2'b01,
        NVMAC_WRITING = 2'b10
    } nvmac_phase_t;

    typedef struct packed {
        logic                       awvalid;
        logic [`NVMAC_ADDR_W-1:0]   awaddr;
        logic                       wvalid;
        logic [`NVMAC_DATA_W-1:0]   wdata;
        logic [`NVMAC_DATA_W/8-1:0] wstrb;
        logic                       bready;
        logic                       arvalid;
        logic [`NVMAC_ADDR_W-1:0]   araddr;
        logic                       rready;
    } nvmac_axil_req_t;

    typedef struct packed {
        logic                     awready;
        logic                     wready;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        logic [`NVMAC_DATA_W-1:0] rdata;
        logic [1:0]               rresp;
    } nvmac_axil_rsp_t;

    // Request toward the array sequencer
    typedef struct packed {
        logic write_req;
        logic erase;
        logic mem_space;
        logic cfg_space;
        logic read_strobe;
        logic abort;
    } nvmac_array_req_t;

    typedef struct packed {
        logic [`NVMAC_SYNC_STAGES-1:0] sync;
        logic                          level;
    } nvmac_pin_sync_t;

    typedef struct packed {
        nvmac_phase_t               phase;
        nvmac_ctrl_t                ctrl;
        logic [`NVMAC_IRQ_W-1:0]    status;
        logic [`NVMAC_IRQ_W-1:0]    mask;
        logic                       irq;
        nvmac_pin_sync_t            ext_pin;
        nvmac_pin_sync_t            wdog_pin;
        nvmac_array_req_t           array;
        logic                       aw_held;
        logic [`NVMAC_ADDR_W-1:0]   awaddr;
        logic                       w_held;
        logic [`NVMAC_DATA_W-1:0]   wdata;
        logic [`NVMAC_DATA_W/8-1:0] wstrb;
        nvmac_axil_rsp_t            rsp;
    } nvmac_state_t;

endpackage : nvmac_pkg

//--- hw/nvmac_top.sv
// Control and status logic for self-timed program flash and data EEPROM access
`timescale 1ns/1ns
`include "nvmac_defs.svh"

module nvmac_top (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // AXI4-Lite register port
    input  wire nvmac_pkg::nvmac_axil_req_t axi_req,
    output      nvmac_pkg::nvmac_axil_rsp_t axi_rsp,
    // Device reset sources, asynchronous pins
    input  wire logic                       external_reset_pin,
    input  wire logic                       watchdog_timeout,
    // Array sequencer
    output      nvmac_pkg::nvmac_array_req_t array_req,
    input  wire logic                       array_write_done,
    // Interrupt
    output      logic                       irq
);
    import nvmac_pkg::*;

    localparam nvmac_state_t RESET_STATE = '{
        phase:   NVMAC_IDLE,
        ctrl:    `NVMAC_CTRL_RESET,
        status:  `NVMAC_IRQ_STATUS_RESET,
        mask:    `NVMAC_IRQ_MASK_RESET,
        default: '0
    };

    nvmac_state_t             st;
    nvmac_state_t             next_st;
    logic                     wr_fire;
    logic [7:0]               wr_byte;
    logic                     wr_ctrl;
    logic                     wr_status;
    logic                     wr_mask;
    logic                     busy;
    logic                     device_reset;
    logic [`NVMAC_IRQ_W-1:0]  irq_set;
    logic [`NVMAC_IRQ_W-1:0]  irq_clear;

    // Known register offsets
    function automatic logic reg_known(input logic [`NVMAC_ADDR_W-1:0] addr);
        reg_known = (addr == `NVMAC_CTRL_OFFSET) ||
                    (addr == `NVMAC_IRQ_STATUS_OFFSET) ||
                    (addr == `NVMAC_IRQ_MASK_OFFSET);
    endfunction : reg_known

    // Read view of the register file; unmapped words read zero
    function automatic logic [`NVMAC_DATA_W-1:0] read_word(
        input logic [`NVMAC_ADDR_W-1:0] addr,
        input nvmac_ctrl_t              ctrl,
        input logic [`NVMAC_IRQ_W-1:0]  status,
        input logic [`NVMAC_IRQ_W-1:0]  mask
    );
        logic [7:0] view;
        view = ctrl;
        view[`NVMAC_BIT_UNUSED] = 1'b0;
        read_word = '0;
        if (addr == `NVMAC_CTRL_OFFSET) begin
            read_word[7:0] = view;
        end else if (addr == `NVMAC_IRQ_STATUS_OFFSET) begin
            read_word[`NVMAC_IRQ_W-1:0] = status;
        end else if (addr == `NVMAC_IRQ_MASK_OFFSET) begin
            read_word[`NVMAC_IRQ_W-1:0] = mask;
        end
    endfunction : read_word

    always_comb begin
        next_st = st;
        irq_set = '0;
        irq_clear = '0;
        busy = (st.phase == NVMAC_WRITING);

        // Pulses to the array last one cycle
        next_st.array.read_strobe = 1'b0;
        next_st.array.abort = 1'b0;

        // Pin filters: a change is taken once the last two stages agree
        next_st.ext_pin.sync = {st.ext_pin.sync[`NVMAC_SYNC_STAGES-2:0], external_reset_pin};
        next_st.wdog_pin.sync = {st.wdog_pin.sync[`NVMAC_SYNC_STAGES-2:0], watchdog_timeout};
        if (st.ext_pin.sync[2] == st.ext_pin.sync[1]) begin
            next_st.ext_pin.level = st.ext_pin.sync[2];
        end
        if (st.wdog_pin.sync[2] == st.wdog_pin.sync[1]) begin
            next_st.wdog_pin.level = st.wdog_pin.sync[2];
        end
        device_reset = st.ext_pin.level || st.wdog_pin.level;

        // Write address and data are accepted in either order
        if (axi_req.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = axi_req.wdata;
            next_st.wstrb = axi_req.wstrb;
        end
        if (st.rsp.bvalid && axi_req.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end

        wr_fire = st.aw_held && st.w_held && !st.rsp.bvalid;
        wr_byte = st.wdata[7:0];
        wr_ctrl = wr_fire && st.wstrb[0] && (st.awaddr == `NVMAC_CTRL_OFFSET);
        wr_status = wr_fire && st.wstrb[0] && (st.awaddr == `NVMAC_IRQ_STATUS_OFFSET);
        wr_mask = wr_fire && st.wstrb[0] && (st.awaddr == `NVMAC_IRQ_MASK_OFFSET);
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = reg_known(st.awaddr) ? `NVMAC_RESP_OKAY : `NVMAC_RESP_SLVERR;
        end

        // A read launch lives for exactly one cycle
        if (st.ctrl.read_launch) begin
            next_st.ctrl.read_launch = 1'b0;
            irq_set[`NVMAC_IRQ_READ_DONE] = 1'b1;
        end

        // Software write to the control register
        if (wr_ctrl) begin
            // Space and erase selects are frozen while a cycle runs
            if (!busy) begin
                next_st.ctrl.memory_space_select = wr_byte[`NVMAC_BIT_MEMORY_SPACE];
                next_st.ctrl.config_space_select = wr_byte[`NVMAC_BIT_CONFIG_SPACE];
                next_st.ctrl.row_erase = wr_byte[`NVMAC_BIT_ROW_ERASE];
            end
            next_st.ctrl.program_allow = wr_byte[`NVMAC_BIT_PROGRAM_ALLOW];
            // Software may only clear the abort flag, never raise it
            if (!wr_byte[`NVMAC_BIT_ABORT_FLAG]) begin
                next_st.ctrl.cycle_abort_flag = 1'b0;
            end
            // A zero on write_launch is simply not acted upon
            if (wr_byte[`NVMAC_BIT_WRITE_LAUNCH] && !busy && !device_reset) begin
                if (st.ctrl.program_allow) begin
                    next_st.ctrl.write_launch = 1'b1;
                    next_st.phase = NVMAC_WRITING;
                    next_st.array.write_req = 1'b1;
                    next_st.array.erase = next_st.ctrl.row_erase;
                    next_st.array.mem_space = next_st.ctrl.memory_space_select;
                    next_st.array.cfg_space = next_st.ctrl.config_space_select;
                end
            end
            // Reads go to data EEPROM only; a flash selection refuses the launch
            if (wr_byte[`NVMAC_BIT_READ_LAUNCH] && !busy && !st.ctrl.read_launch &&
                !next_st.ctrl.memory_space_select) begin
                next_st.ctrl.read_launch = 1'b1;
                next_st.array.read_strobe = 1'b1;
                next_st.array.erase = 1'b0;
                next_st.array.mem_space = 1'b0;
                next_st.array.cfg_space = next_st.ctrl.config_space_select;
            end
        end

        // Hardware end of a self-timed cycle, applied after software so it wins
        if (busy) begin
            if (device_reset) begin
                // Selects are left alone so software can see what failed
                next_st.ctrl.cycle_abort_flag = 1'b1;
                next_st.ctrl.write_launch = 1'b0;
                next_st.ctrl.program_allow = 1'b0;
                next_st.ctrl.memory_space_select = st.ctrl.memory_space_select;
                next_st.ctrl.row_erase = st.ctrl.row_erase;
                next_st.phase = NVMAC_IDLE;
                next_st.array.write_req = 1'b0;
                next_st.array.abort = 1'b1;
                irq_set[`NVMAC_IRQ_ABORT] = 1'b1;
            end else if (array_write_done) begin
                next_st.ctrl.write_launch = 1'b0;
                next_st.ctrl.row_erase = 1'b0;
                next_st.phase = NVMAC_IDLE;
                next_st.array.write_req = 1'b0;
                irq_set[`NVMAC_IRQ_WRITE_DONE] = 1'b1;
            end
        end
        next_st.ctrl.unused = 1'b0;

        // Sticky interrupt status: a new event beats a same-cycle clear
        if (wr_status) begin
            irq_clear = wr_byte[`NVMAC_IRQ_W-1:0];
        end
        if (wr_mask) begin
            next_st.mask = wr_byte[`NVMAC_IRQ_W-1:0];
        end
        next_st.status = (st.status & ~irq_clear) | irq_set;
        next_st.irq = |(next_st.status & next_st.mask);

        // Read channel: one read at a time, data captured at the address handshake
        if (st.rsp.rvalid && axi_req.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st.rsp.arready) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata = read_word(axi_req.araddr, st.ctrl, st.status, st.mask);
            next_st.rsp.rresp = reg_known(axi_req.araddr) ? `NVMAC_RESP_OKAY : `NVMAC_RESP_SLVERR;
        end

        // Ready flops: no new beat while one is held or a response waits
        next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
        next_st.rsp.wready = !next_st.w_held && !next_st.rsp.bvalid;
        next_st.rsp.arready = !next_st.rsp.rvalid;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp = st.rsp;
    assign array_req = st.array;
    assign irq = st.irq;

endmodule : nvmac_top

//--- verif/nvmac_properties.sv
// Port-level checks for the nonvolatile access control block
`timescale 1ns/1ns
module nvmac_properties (
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        rst,
    // Register port
    input wire nvmac_pkg::nvmac_axil_req_t  axi_req,
    input wire nvmac_pkg::nvmac_axil_rsp_t  axi_rsp,
    // Reset sources, array side, interrupt
    input wire logic                        external_reset_pin,
    input wire logic                        watchdog_timeout,
    input wire nvmac_pkg::nvmac_array_req_t array_req,
    input wire logic                        array_write_done,
    input wire logic                        irq
);
    import nvmac_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_read_pulse: assert property (array_req.read_strobe |=> !array_req.read_strobe)
        else $error("read strobe longer than one cycle");
    a_read_by_write: assert property (array_req.read_strobe |-> $rose(axi_rsp.bvalid))
        else $error("read strobe without a register write");
    a_read_not_flash: assert property (array_req.read_strobe |-> !array_req.mem_space && !array_req.write_req)
        else $error("read started on flash or during a write");
    a_launch_by_write: assert property ($rose(array_req.write_req) |-> $rose(axi_rsp.bvalid))
        else $error("write cycle started without a register write");
    a_done_ends_cycle: assert property (array_req.write_req && array_write_done |=> !array_req.write_req)
        else $error("write cycle did not end on done");
    a_selects_held: assert property (array_req.write_req && $past(array_req.write_req) |->
        $stable(array_req.erase) && $stable(array_req.mem_space) && $stable(array_req.cfg_space))
        else $error("cycle selects changed mid cycle");
    a_abort_cuts: assert property (array_req.abort |-> $past(array_req.write_req) && !array_req.write_req)
        else $error("abort outside a running cycle");
    a_abort_pulse: assert property (array_req.abort |=> !array_req.abort)
        else $error("abort longer than one cycle");
    a_bit5_zero: assert property (axi_rsp.rvalid |-> !axi_rsp.rdata[5] && axi_rsp.rdata[31:8] == 24'h0)
        else $error("unused read bits not zero");
    a_abort_keeps_sel: assert property (array_req.abort |->
        $stable(array_req.mem_space) && $stable(array_req.erase))
        else $error("selects changed on abort");
    a_end_by_hw: assert property ($fell(array_req.write_req) |-> $past(array_write_done) || array_req.abort)
        else $error("write cycle ended without done or abort");
endmodule : nvmac_properties

bind nvmac_top nvmac_properties i_nvmac_properties (.clock, .rst, .axi_req, .axi_rsp, .external_reset_pin,
    .watchdog_timeout, .array_req, .array_write_done, .irq);

//--- verif/tb_top.sv
// Register-level bench for the nonvolatile access control block
`timescale 1ns/1ns
module tb_top;
    import nvmac_pkg::*;
    logic             clock = 1'b0;
    logic             rst = 1'b1;
    nvmac_axil_req_t  req = '0;
    nvmac_axil_rsp_t  rsp;
    logic             ext_pin = 1'b0;
    logic             wdog_pin = 1'b0;
    logic [3:0]       strb = 4'hf;
    nvmac_array_req_t areq;
    logic             done = 1'b0;
    logic             irq;
    logic             rd_cfg;
    logic [31:0]      d;
    logic [1:0]       r;
    int               n_fail = 0;
    int               n_checks = 0;
    int               n_rd = 0;
    int               n_ab = 0;
    int               k;

    always #5 clock = ~clock;

    nvmac_top i_nvmac_top (.clock(clock), .rst(rst), .axi_req(req), .axi_rsp(rsp), .external_reset_pin(ext_pin),
        .watchdog_timeout(wdog_pin), .array_req(areq), .array_write_done(done), .irq(irq));

    // One-cycle strobes are counted here so register polling cannot miss them
    always @(posedge clock) begin
        if (!rst && areq.read_strobe) begin
            n_rd++;
            rd_cfg = areq.cfg_space;
        end
        if (!rst && areq.abort) n_ab++;
    end

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32

    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    // Both write channels offered together; bready held until the response
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= strb;
        req.bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk32("rresp", 32'h0, {30'h0, r});
        chk32("rdata", e, d);
    endtask : rchk

    task automatic give_verdict;
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rchk(32'h0, 32'h0);
        rchk(32'h4, 32'h0);
        rchk(32'h8, 32'h0);
        rd(32'h10);
        chk32("rresp", 32'h2, {30'h0, r});
        wr(32'h10, 32'hff);
        chk32("bresp", 32'h2, {30'h0, r});
        wr(32'h0, 32'he0);
        chk32("bresp", 32'h0, {30'h0, r});
        rchk(32'h0, 32'hc0);
        wr(32'h0, 32'h81);
        rchk(32'h0, 32'h80);
        chk32("reads", 32'h0, n_rd);
        wr(32'h0, 32'h41);
        rchk(32'h0, 32'h40);
        chk32("reads", 32'h1, n_rd);
        chk1("cfg", 1'b1, rd_cfg);
        wr(32'h0, 32'h01);
        rchk(32'h0, 32'h0);
        chk1("cfg", 1'b0, rd_cfg);
        rchk(32'h4, 32'h2);
        chk1("irq", 1'b0, irq);
        wr(32'h8, 32'h2);
        rchk(32'h8, 32'h2);
        chk1("irq", 1'b1, irq);
        wr(32'h4, 32'h2);
        rchk(32'h4, 32'h0);
        chk1("irq", 1'b0, irq);
        wr(32'h0, 32'h02);
        rchk(32'h0, 32'h0);
        wr(32'h0, 32'h06);
        rchk(32'h0, 32'h04);
        wr(32'h0, 32'h16);
        @(posedge clock);
        chk1("write_req", 1'b1, areq.write_req);
        chk1("erase", 1'b1, areq.erase);
        wr(32'h0, 32'h84);
        rchk(32'h0, 32'h16);
        done <= 1'b1;
        @(posedge clock);
        done <= 1'b0;
        rchk(32'h0, 32'h04);
        chk1("write_req", 1'b0, areq.write_req);
        rchk(32'h4, 32'h1);
        // Both device reset sources must cut a running cycle
        for (k = 0; k < 2; k++) begin
            wr(32'h4, 32'h7);
            wr(32'h0, 32'h04);
            wr(32'h0, 32'h96);
            @(posedge clock);
            chk1("mem_space", 1'b1, areq.mem_space);
            ext_pin <= (k == 0);
            wdog_pin <= (k == 1);
            while (n_ab == k) @(posedge clock);
            ext_pin <= 1'b0;
            wdog_pin <= 1'b0;
            rchk(32'h0, 32'h98);
            rchk(32'h4, 32'h4);
            wr(32'h0, 32'h00);
            rchk(32'h0, 32'h0);
        end
        // Abort status left set drives the interrupt once unmasked
        wr(32'h8, 32'h4);
        chk1("irq", 1'b1, irq);
        // A mid-run reset brings every register back to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk1("irq", 1'b0, irq);
        rchk(32'h4, 32'h0);
        rchk(32'h8, 32'h0);
        rchk(32'h0, 32'h0);
        // Writes without byte lane 0 are answered but change nothing
        strb = 4'he;
        wr(32'h8, 32'h7);
        strb = 4'hf;
        chk32("bresp", 32'h0, {30'h0, r});
        rchk(32'h8, 32'h0);
        give_verdict();
    end
endmodule : tb_top
